/* File: design/ubrg_core.sv */
// baud rate generator: fractional prescaler, 16-bit divisor, oversampling count, 1x clock mode
// How it works
// - sixteen-bit divisor from high and low bytes
// - bit rate is clock over sc*divisor*prescale
// - reset bypasses prescaler, oversampling register zero
// - prescaler ratio is M plus N eighths
// - prescaler enable low forces ratio one
// - low nibble codes clocks per bit
// - oversampling register upper nibble reads zero
// - oversampling register reads back only the low nibble last written
// - codes 01, 10, 11 stay sixteen clocks
// - oversampling count ignored in isochronous mode
// - oversampling register needs no enhanced mode
// - transmitter clock on ring pin, receiver on dsr
// - select bits 7 and 3 choose isochronous
// - isochronous shifts one bit per 1x clock
// - local 1x clock can drive dtr pin
// - select bits 4/5 put clocks on dtr
`timescale 1ns/1ps
module ubrg_core (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic ring_indicator_pin,
   input wire logic dsr_pin,
   input wire logic dtr_modem_n,
   output logic dtr_n,
   output logic tx_bit_en,
   output logic rx_sample_en,
   output logic tx_isochronous,
   output logic rx_isochronous,
   output logic [4:0] tx_clocks_per_bit,
   output logic [4:0] rx_clocks_per_bit
);

   // decode of the oversampling code into clocks per bit
   function automatic logic [4:0] ubrg_clocks_per_bit(input logic [7:0] code);
      logic [4:0] n;
      n = ubrg_pkg::CLOCKS_PER_BIT_DEFAULT;
      // only the low nibble matters, so 0x10 and 0x11 fall back to sixteen
      if (code[3:0] >= ubrg_pkg::CLOCKS_PER_BIT_MIN_CODE) begin
         n = {1'b0, code[3:0]};
      end
      return n;
   endfunction

   // software visible registers
   logic [7:0] clock_prescale; // M in the upper five bits, N in the lower three
   logic [7:0] sample_clock_count; // kept whole, though reads return only the low nibble
   logic [7:0] clock_select_register; // isochronous, source and dtr selects
   logic [7:0] divisor_low_byte; // lower half of the divisor
   logic [7:0] divisor_high_byte; // upper half of the divisor
   logic [7:0] mode_control; // holds the prescaler enable bit
   logic [7:0] enhanced_control; // holds the enhanced mode enable bit

   // generator state
   logic [5:0] pre_cnt; // cycles into the current prescaler period
   logic [2:0] frac_acc; // fraction accumulator, one carry per eighth overflow
   logic pre_extra; // current prescaler period is M+1 long
   logic [15:0] div_cnt; // prescaled ticks into the divisor period
   logic [3:0] os_cnt; // sample enables into the current bit
   logic gen_clk; // square wave toggled on each sample enable
   logic tx_clk_prev; // last level of the transmitter 1x clock
   logic rx_clk_prev; // last level of the receiver 1x clock

   // derived values
   logic prescaler_on;
   logic [5:0] m_eff;
   logic [5:0] pre_len;
   logic pre_tick;
   logic [3:0] frac_sum;
   logic [15:0] divisor;
   logic [15:0] div_eff;
   logic sample_pulse;
   logic [4:0] sc;
   logic bit_wrap;
   logic tx_clk_src;
   logic rx_clk_src;
   logic tx_edge;
   logic rx_edge;
   logic next_tx_bit_en;
   logic next_rx_sample_en;
   logic next_dtr_n;
   logic [7:0] next_rdata;

   // prescaler ratio and bypass
   assign prescaler_on = mode_control[ubrg_pkg::PRESCALER_ENABLE_BIT];
   // M of zero is outside the range and acts as one
   assign m_eff = (clock_prescale[7:ubrg_pkg::PRESCALE_M_LSB] == 5'h00) ? 6'h01 :
                  {1'b0, clock_prescale[7:ubrg_pkg::PRESCALE_M_LSB]};
   assign pre_len = m_eff + {5'h00, pre_extra};
   assign frac_sum = {1'b0, frac_acc} + {1'b0, clock_prescale[ubrg_pkg::PRESCALE_N_MSB:0]};
   // bypass gives a tick on every clock, an exact ratio of one
   assign pre_tick = !prescaler_on || (pre_cnt >= (pre_len - 6'h01));

   // divisor, a zero value is treated as one so the generator never stalls
   assign divisor = {divisor_high_byte, divisor_low_byte};
   assign div_eff = (divisor == 16'h0000) ? 16'h0001 : divisor;
   assign sample_pulse = pre_tick && (div_cnt >= (div_eff - 16'h0001));

   // oversampling count takes effect in any mode, no enhanced gate
   assign sc = ubrg_clocks_per_bit(sample_clock_count);
   assign bit_wrap = sample_pulse && ({1'b0, os_cnt} >= (sc - 5'h01));

   // 1x clock sources: external pin or the local generator clock
   assign tx_clk_src = clock_select_register[ubrg_pkg::TX_EXT_CLOCK_SELECT] ?
                       ring_indicator_pin : gen_clk;
   assign rx_clk_src = clock_select_register[ubrg_pkg::RX_EXT_CLOCK_SELECT] ?
                       dsr_pin : gen_clk;
   // each rising edge of the 1x clock shifts one bit
   assign tx_edge = tx_clk_src && !tx_clk_prev;
   assign rx_edge = rx_clk_src && !rx_clk_prev;

   // isochronous flags straight from the select register
   assign tx_isochronous = clock_select_register[ubrg_pkg::TX_ISOCHRONOUS_SELECT];
   assign rx_isochronous = clock_select_register[ubrg_pkg::RX_ISOCHRONOUS_SELECT];
   // framing logic sees one clock per bit in isochronous mode
   assign tx_clocks_per_bit = tx_isochronous ? ubrg_pkg::CLOCKS_PER_BIT_ISO : sc;
   assign rx_clocks_per_bit = rx_isochronous ? ubrg_pkg::CLOCKS_PER_BIT_ISO : sc;

   // prescaler counter mixing M and M+1 periods, one M+1 per carry of the N eighths
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt <= 6'h00;
         frac_acc <= 3'h0;
         pre_extra <= 1'b0;
      end else if (!prescaler_on) begin
         // held clear so enabling starts a clean period
         pre_cnt <= 6'h00;
         frac_acc <= 3'h0;
         pre_extra <= 1'b0;
      end else if (pre_tick) begin
         // carry out of the eighths makes the next period one longer
         pre_cnt <= 6'h00;
         frac_acc <= frac_sum[2:0];
         pre_extra <= frac_sum[3];
      end else begin
         pre_cnt <= pre_cnt + 6'h01;
      end
   end

   // divisor counter advanced by prescaled ticks
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= 16'h0000;
      end else if (sample_pulse) begin
         // >= compare restarts cleanly if the divisor shrinks mid period
         div_cnt <= 16'h0000;
      end else if (pre_tick) begin
         div_cnt <= div_cnt + 16'h0001;
      end
   end

   // oversampling counter, one bit time per programmed count
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         os_cnt <= 4'h0;
      end else if (bit_wrap) begin
         os_cnt <= 4'h0;
      end else if (sample_pulse) begin
         os_cnt <= os_cnt + 4'h1;
      end
   end

   // local square clock, one half period per sample enable
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gen_clk <= 1'b0;
      end else if (sample_pulse) begin
         gen_clk <= !gen_clk;
      end
   end

   // previous levels of the 1x clocks for edge detection
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_clk_prev <= 1'b0;
         rx_clk_prev <= 1'b0;
      end else begin
         tx_clk_prev <= tx_clk_src;
         rx_clk_prev <= rx_clk_src;
      end
   end

   // enables to the transmitter and receiver
   always_comb begin
      // oversampled mode: transmitter shifts once per bit time
      next_tx_bit_en = bit_wrap;
      next_rx_sample_en = sample_pulse;
      if (tx_isochronous) begin
         next_tx_bit_en = tx_edge;
      end
      if (rx_isochronous) begin
         next_rx_sample_en = rx_edge;
      end
   end

   // dtr pin: clock output when selected, otherwise the modem control level
   always_comb begin
      next_dtr_n = dtr_modem_n;
      if (clock_select_register[ubrg_pkg::DTR_TX_CLOCK_SELECT]) begin
         // transmitter clock wins when both selects are set
         next_dtr_n = tx_clk_src;
      end else if (clock_select_register[ubrg_pkg::DTR_NX_CLOCK_SELECT]) begin
         next_dtr_n = gen_clk;
      end
   end

   // output flops so pins and enables are glitch free
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_bit_en <= 1'b0;
         rx_sample_en <= 1'b0;
         dtr_n <= 1'b1;
      end else begin
         tx_bit_en <= next_tx_bit_en;
         rx_sample_en <= next_rx_sample_en;
         dtr_n <= next_dtr_n;
      end
   end

   // prescale, oversampling and select register writes
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         clock_prescale <= ubrg_pkg::RST_CLOCK_PRESCALE;
         sample_clock_count <= ubrg_pkg::RST_SAMPLE_CLOCK_COUNT;
         clock_select_register <= ubrg_pkg::RST_CLOCK_SELECT;
      end else if (reg_wr) begin
         unique case (reg_addr)
            ubrg_pkg::ADDR_CLOCK_PRESCALE: begin
               clock_prescale <= reg_wdata;
            end
            ubrg_pkg::ADDR_SAMPLE_CLOCK_COUNT: begin
               // stored whole, no enhanced mode check
               sample_clock_count <= reg_wdata;
            end
            ubrg_pkg::ADDR_CLOCK_SELECT: begin
               clock_select_register <= reg_wdata;
            end
            default: begin
            end
         endcase
      end
   end

   // divisor byte writes
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         divisor_low_byte <= ubrg_pkg::RST_DIVISOR_LOW;
         divisor_high_byte <= ubrg_pkg::RST_DIVISOR_HIGH;
      end else if (reg_wr && (reg_addr == ubrg_pkg::ADDR_DIVISOR_LOW)) begin
         divisor_low_byte <= reg_wdata;
      end else if (reg_wr && (reg_addr == ubrg_pkg::ADDR_DIVISOR_HIGH)) begin
         divisor_high_byte <= reg_wdata;
      end
   end

   // enhanced mode control
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         enhanced_control <= ubrg_pkg::RST_ENHANCED_CONTROL;
      end else if (reg_wr && (reg_addr == ubrg_pkg::ADDR_ENHANCED_CONTROL)) begin
         enhanced_control <= reg_wdata;
      end
   end

   // mode control: prescaler enable only changes while enhanced mode is on
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mode_control <= ubrg_pkg::RST_MODE_CONTROL;
      end else if (reg_wr && (reg_addr == ubrg_pkg::ADDR_MODE_CONTROL)) begin
         // other bits always take the write; a driver that skips enhanced
         // mode finds the prescaler enable unchanged
         mode_control[6:0] <= reg_wdata[6:0];
         if (enhanced_control[ubrg_pkg::ENHANCED_MODE_ENABLE_BIT]) begin
            mode_control[ubrg_pkg::PRESCALER_ENABLE_BIT] <=
               reg_wdata[ubrg_pkg::PRESCALER_ENABLE_BIT];
         end
      end
   end

   // read multiplexer
   always_comb begin
      next_rdata = ubrg_pkg::READ_UNMAPPED;
      unique case (reg_addr)
         ubrg_pkg::ADDR_CLOCK_PRESCALE: begin
            next_rdata = clock_prescale;
         end
         ubrg_pkg::ADDR_SAMPLE_CLOCK_COUNT: begin
            // upper nibble reads zero, low nibble as written, in every mode
            next_rdata = {4'h0, sample_clock_count[3:0]};
         end
         ubrg_pkg::ADDR_CLOCK_SELECT: begin
            next_rdata = clock_select_register;
         end
         ubrg_pkg::ADDR_DIVISOR_LOW: begin
            next_rdata = divisor_low_byte;
         end
         ubrg_pkg::ADDR_DIVISOR_HIGH: begin
            next_rdata = divisor_high_byte;
         end
         ubrg_pkg::ADDR_MODE_CONTROL: begin
            next_rdata = mode_control;
         end
         ubrg_pkg::ADDR_ENHANCED_CONTROL: begin
            next_rdata = enhanced_control;
         end
         ubrg_pkg::ADDR_GEN_STATUS: begin
            // live state: prescaler on, iso flags, decoded oversampling clocks per bit even in isochronous mode
            next_rdata = {prescaler_on, rx_isochronous, tx_isochronous, sc};
         end
         default: begin
            next_rdata = ubrg_pkg::READ_UNMAPPED;
         end
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule // ubrg_core

/* File: design/ubrg_pkg.sv */
// package of offsets, field positions, reset values and counts for the baud rate generator
package ubrg_pkg;
   // register offsets (byte addresses on the plain register port)
   localparam logic [7:0] ADDR_CLOCK_PRESCALE = 8'h01;
   localparam logic [7:0] ADDR_SAMPLE_CLOCK_COUNT = 8'h02;
   localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h03;
   localparam logic [7:0] ADDR_DIVISOR_LOW = 8'h04;
   localparam logic [7:0] ADDR_DIVISOR_HIGH = 8'h05;
   localparam logic [7:0] ADDR_MODE_CONTROL = 8'h06;
   localparam logic [7:0] ADDR_ENHANCED_CONTROL = 8'h07;
   localparam logic [7:0] ADDR_GEN_STATUS = 8'h08;
   // field positions
   localparam int PRESCALE_M_LSB = 3;
   localparam int PRESCALE_N_MSB = 2;
   localparam int PRESCALER_ENABLE_BIT = 7;
   localparam int ENHANCED_MODE_ENABLE_BIT = 4;
   localparam int TX_ISOCHRONOUS_SELECT = 7;
   localparam int TX_EXT_CLOCK_SELECT = 6;
   localparam int DTR_NX_CLOCK_SELECT = 5;
   localparam int DTR_TX_CLOCK_SELECT = 4;
   localparam int RX_ISOCHRONOUS_SELECT = 3;
   localparam int RX_EXT_CLOCK_SELECT = 2;
   // values after reset
   localparam logic [7:0] RST_CLOCK_PRESCALE = 8'h08;
   localparam logic [7:0] RST_SAMPLE_CLOCK_COUNT = 8'h00;
   localparam logic [7:0] RST_CLOCK_SELECT = 8'h00;
   localparam logic [7:0] RST_DIVISOR_LOW = 8'h01;
   localparam logic [7:0] RST_DIVISOR_HIGH = 8'h00;
   localparam logic [7:0] RST_MODE_CONTROL = 8'h00;
   localparam logic [7:0] RST_ENHANCED_CONTROL = 8'h00;
   // counts
   localparam logic [4:0] CLOCKS_PER_BIT_DEFAULT = 5'h10;
   localparam logic [3:0] CLOCKS_PER_BIT_MIN_CODE = 4'h4;
   localparam logic [4:0] CLOCKS_PER_BIT_ISO = 5'h01;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
endpackage

/* File: tb/uart_baud_rate_generator_tb.sv */
// self-checking bench for the baud rate generator
`timescale 1ns/1ps
module uart_baud_rate_generator_tb;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic reg_wr = 1'b0, reg_rd = 1'b0, dtr_modem_n = 1'b1, run = 1'b0;
   logic [3:0] half = 4'h1; // far-side clock half period
   logic ri, dsr, dtr_n, tx_bit_en, rx_sample_en, tx_iso, rx_iso;
   logic [4:0] tx_cpb, rx_cpb;
   int n_mismatch = 0, checked = 0, cycles = 0;
   int n_ri, n_dsr, n_tx, n_rx; // far-side model edge counts and dut enable pulse counts
   logic last_ri, last_dsr;
   // reset table: addresses and expected values, last one unmapped
   logic [7:0] ra [5] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h09};
   logic [7:0] re [5] = '{8'h08, 8'h00, 8'h01, 8'h00, 8'h00};
   always #25 mclk = ~mclk;
   ubrg_core dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ring_indicator_pin(ri),
      .dsr_pin(dsr), .dtr_modem_n(dtr_modem_n), .dtr_n(dtr_n), .tx_bit_en(tx_bit_en),
      .rx_sample_en(rx_sample_en), .tx_isochronous(tx_iso), .rx_isochronous(rx_iso),
      .tx_clocks_per_bit(tx_cpb), .rx_clocks_per_bit(rx_cpb));
   ubrg_ext_clock far (.mclk(mclk), .run(run), .half(half), .ring_indicator_pin(ri),
      .dsr_pin(dsr));
   // random modem dtr level keeps the pass-through path busy
   always @(posedge mclk) dtr_modem_n <= 1'($urandom);
   // hang guard: ceiling well above the roughly 20k cycles the tests need
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 40000) begin
         n_mismatch++;
         $display("MISMATCH at %0t: timeout", $time);
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // compare of register and port values
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // compare of cycle and pulse counts
   task automatic chk_int(input int got, input int exp, input string what);
      checked++;
      if (got != exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // cycles from one enable pulse to the n-th after it; sampled on the falling edge
   task automatic meas(input bit tx, input int n, output int cyc);
      int seen;
      seen = -1;
      cyc = 0;
      while (seen < n && cyc < 20000) begin
         @(negedge mclk);
         if (seen >= 0) cyc++;
         if ((tx ? tx_bit_en : rx_sample_en) === 1'b1) seen++;
      end
   endtask
   // dtr pin against its source one cycle earlier: 0 modem level, 1 ring clock, 2 local clock
   task automatic dtr_follow(input int src, input int n);
      logic exp;
      exp = 1'b0;
      for (int k = 0; k < n; k++) begin
         @(negedge mclk);
         // only the first cycle after a select write still carries the old source; the first two are skipped
         if (k > 1) chk({7'h0, dtr_n}, {7'h0, exp}, "dtr pin source");
         // local clock toggles on every cycle with divisor one and the prescaler bypassed
         exp = (src == 0) ? dtr_modem_n : (src == 1) ? ri : ~dtr_n;
      end
   endtask
   // counts far-side clock rises and enable pulses over n cycles
   task automatic watch(input int n);
      repeat (n) begin
         @(negedge mclk);
         n_ri += int'(ri & ~last_ri);
         n_dsr += int'(dsr & ~last_dsr);
         n_tx += int'(tx_bit_en);
         n_rx += int'(rx_sample_en);
         last_ri = ri;
         last_dsr = dsr;
      end
   endtask
   initial begin
      logic [7:0] d, v;
      int c, dv, sc, pr;
      bit en;
      void'($urandom(32'h134C8329));
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      foreach (ra[i]) begin
         rd(ra[i], d);
         chk(d, re[i], "reset value");
      end
      chk({3'h0, tx_cpb}, 8'h10, "default count");
      meas(1'b1, 1, c);
      meas(1'b1, 8, c);
      chk_int(c, 8 * 16, "default bit time");
      $display("test reset done");
      for (int code = 0; code < 16; code++) begin
         v = {4'($urandom), 4'(code)};
         wr(ubrg_pkg::ADDR_SAMPLE_CLOCK_COUNT, v);
         rd(ubrg_pkg::ADDR_SAMPLE_CLOCK_COUNT, d);
         chk(d, {4'h0, v[3:0]}, "count readback");
         chk({3'h0, tx_cpb}, (code < 4) ? 8'h10 : 8'(code), "clocks per bit");
      end
      $display("test count codes done");
      for (int i = 0; i < 4; i++) begin
         en = (i == 1 || i == 2);
         dv = (i == 3) ? 256 : 1 + int'($urandom % 3);
         sc = 4 + int'($urandom % 4);
         pr = 8 * (1 + int'($urandom % 3)) + int'($urandom % 8);
         wr(ubrg_pkg::ADDR_DIVISOR_LOW, 8'(dv));
         wr(ubrg_pkg::ADDR_DIVISOR_HIGH, 8'(dv >> 8));
         wr(ubrg_pkg::ADDR_SAMPLE_CLOCK_COUNT, 8'(sc));
         wr(ubrg_pkg::ADDR_CLOCK_PRESCALE, 8'(pr));
         // enhanced mode first, then the prescaler enable may change
         wr(ubrg_pkg::ADDR_ENHANCED_CONTROL, 8'h10);
         wr(ubrg_pkg::ADDR_MODE_CONTROL, 8'h00);
         wr(ubrg_pkg::ADDR_ENHANCED_CONTROL, en ? 8'h10 : 8'h00);
         wr(ubrg_pkg::ADDR_MODE_CONTROL, 8'h80); // lands only while enhanced
         if (!en) pr = 8; // bypassed: eight pre-ticks per eight cycles
         meas(1'b0, 1, c);
         meas(1'b0, 8, c);
         chk_int(c, dv * pr, "sample spacing");
         meas(1'b1, 1, c);
         meas(1'b1, 8, c);
         chk_int(c, sc * dv * pr, "bit time");
      end
      $display("test rates done");
      wr(ubrg_pkg::ADDR_SAMPLE_CLOCK_COUNT, 8'h05);
      wr(ubrg_pkg::ADDR_CLOCK_SELECT, 8'hCC);
      half <= 4'(1 + $urandom % 4);
      @(negedge mclk);
      chk({3'h0, tx_cpb}, 8'h01, "tx iso count");
      chk({3'h0, rx_cpb}, 8'h01, "rx iso count");
      chk({6'h0, tx_iso, rx_iso}, 8'h03, "iso flags");
      rd(ubrg_pkg::ADDR_GEN_STATUS, d);
      chk(d, 8'h65, "live status");
      {n_ri, n_dsr, n_tx, n_rx} = '0;
      {last_ri, last_dsr} = '0;
      @(posedge mclk);
      run <= 1'b1;
      watch(200);
      @(posedge mclk);
      run <= 1'b0;
      watch(10);
      chk_int(n_tx, n_ri, "tx bits per ring edge");
      chk_int(n_rx, n_dsr, "rx bits per dsr edge");
      // local clocks onto the dtr pin, then the ring clock, then back to modem control
      wr(ubrg_pkg::ADDR_DIVISOR_LOW, 8'h01);
      wr(ubrg_pkg::ADDR_DIVISOR_HIGH, 8'h00);
      wr(ubrg_pkg::ADDR_CLOCK_SELECT, 8'h10);
      dtr_follow(2, 20);
      wr(ubrg_pkg::ADDR_CLOCK_SELECT, 8'h20);
      dtr_follow(2, 20);
      wr(ubrg_pkg::ADDR_CLOCK_SELECT, 8'h50);
      run <= 1'b1;
      dtr_follow(1, 30);
      @(posedge mclk);
      run <= 1'b0;
      wr(ubrg_pkg::ADDR_CLOCK_SELECT, 8'h00);
      dtr_follow(0, 20);
      $display("test isochronous done");
      end_of_test();
   end
endmodule // uart_baud_rate_generator_tb

/* File: tb/ubrg_core_assertions.sv */
// checker: port relations of the baud rate generator
`timescale 1ns/1ps
module ubrg_core_assertions (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic ring_indicator_pin,
   input wire logic dsr_pin,
   input wire logic dtr_modem_n,
   input wire logic dtr_n,
   input wire logic tx_bit_en,
   input wire logic rx_sample_en,
   input wire logic tx_isochronous,
   input wire logic rx_isochronous,
   input wire logic [4:0] tx_clocks_per_bit,
   input wire logic [4:0] rx_clocks_per_bit
);
   logic [7:0] sel_q; // shadow of the clock select register
   // shadow select writes so pin relations know the current mode
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) sel_q <= 8'h00;
      else if (reg_wr && reg_addr == ubrg_pkg::ADDR_CLOCK_SELECT) sel_q <= reg_wdata;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   AST_TX_ISO_SEL: assert property (reg_wr && reg_addr == ubrg_pkg::ADDR_CLOCK_SELECT
      |=> tx_isochronous == $past(reg_wdata[7])) else $error("tx iso flag wrong");
   AST_RX_ISO_SEL: assert property (reg_wr && reg_addr == ubrg_pkg::ADDR_CLOCK_SELECT
      |=> rx_isochronous == $past(reg_wdata[3])) else $error("rx iso flag wrong");
   AST_ISO_CPB: assert property (tx_isochronous |-> tx_clocks_per_bit == 5'h01)
      else $error("iso count not one");
   AST_CPB_RANGE: assert property (!rx_isochronous |-> rx_clocks_per_bit inside {[4:16]})
      else $error("count out of range");
   AST_CPB_DECODE: assert property (reg_wr && reg_addr == ubrg_pkg::ADDR_SAMPLE_CLOCK_COUNT
      && !sel_q[7] |=> tx_clocks_per_bit == (($past(reg_wdata[3:0]) < 4'h4) ? 5'h10
      : {1'b0, $past(reg_wdata[3:0])})) else $error("count decode wrong");
   AST_COUNT_UPPER: assert property (reg_rd && reg_addr == ubrg_pkg::ADDR_SAMPLE_CLOCK_COUNT
      |=> reg_rdata[7:4] == 4'h0) else $error("count upper nibble set");
   AST_TX_PULSE: assert property (tx_bit_en |=> !tx_bit_en)
      else $error("bit enable longer than a cycle");
   AST_DTR_PASS: assert property (sel_q[5:4] == 2'b00 |=> dtr_n == $past(dtr_modem_n))
      else $error("dtr not passed through");
   AST_TX_EXT_CLK: assert property (sel_q[7] && sel_q[6] && $rose(ring_indicator_pin)
      |=> tx_bit_en) else $error("no tx bit on ring clock edge");
   AST_RX_EXT_CLK: assert property (sel_q[3] && sel_q[2] && $rose(dsr_pin)
      |=> rx_sample_en) else $error("no rx bit on dsr clock edge");
   COV_TX_ISO: cover property (sel_q[7] && tx_bit_en);
   COV_DTR_CLK: cover property (sel_q[5:4] != 2'b00 && !dtr_n);
   COV_COUNT_WR: cover property (reg_wr && reg_addr == ubrg_pkg::ADDR_SAMPLE_CLOCK_COUNT);
endmodule // ubrg_core_assertions
bind ubrg_core ubrg_core_assertions chk_i (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .ring_indicator_pin(ring_indicator_pin), .dsr_pin(dsr_pin), .dtr_modem_n(dtr_modem_n),
   .dtr_n(dtr_n), .tx_bit_en(tx_bit_en), .rx_sample_en(rx_sample_en),
   .tx_isochronous(tx_isochronous), .rx_isochronous(rx_isochronous),
   .tx_clocks_per_bit(tx_clocks_per_bit), .rx_clocks_per_bit(rx_clocks_per_bit));

/* File: tb/ubrg_ext_clock.sv */
// far-side model: external 1x clock source on the ring and dsr pins
`timescale 1ns/1ps
module ubrg_ext_clock (
   input wire logic mclk,
   input wire logic run, // frame active; clocks stand still low outside it
   input wire logic [3:0] half, // half period of the ring clock in mclk cycles
   output logic ring_indicator_pin,
   output logic dsr_pin
);
   int cnt; // cycles since last ring clock toggle
   initial ring_indicator_pin = 1'b0;
   initial dsr_pin = 1'b0;
   // ring clock toggles every half cycles, dsr clock at half its rate
   always @(posedge mclk) begin
      if (!run) begin
         // parked low so no stray edge leaks out between frames
         cnt <= 0;
         ring_indicator_pin <= 1'b0;
         dsr_pin <= 1'b0;
      end else if (cnt >= int'(half) - 1) begin
         cnt <= 0;
         ring_indicator_pin <= ~ring_indicator_pin;
         if (ring_indicator_pin) dsr_pin <= ~dsr_pin;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule // ubrg_ext_clock
